//--- rtl/cpu_priv_params.svh
// Purpose : Constants for the privileged register bank
// Assumes : Included by the package and the testbench
// Notes   : Register selects are move-to/move-from register numbers
`ifndef CPU_PRIV_PARAMS_SVH
`define CPU_PRIV_PARAMS_SVH

// ----------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------
`define SEL_W              5
`define SEL_MODE           5'h00
`define SEL_EXCEPTION_SUMMARY        5'h01
`define SEL_FW_BASE        5'h02
`define SEL_HW_IRQ_REQ     5'h03
`define SEL_SW_IRQ_REQ     5'h04
`define SEL_ASYNC_REQ      5'h05
`define SEL_HW_IRQ_EN      5'h06
`define SEL_SW_IRQ_EN      5'h07
`define SEL_ASYNC_EN       5'h08
`define SEL_SERIAL_TX      5'h09
`define SEL_XLATE_CTL      5'h0a
`define SEL_DX_ENTRY       5'h0b
`define SEL_DX_HOLD        5'h0c
`define SEL_FAULT_STATUS   5'h0d
`define SEL_FAULT_VA       5'h0e
`define SEL_DX_ZAP         5'h0f
`define SEL_DX_GLOBAL_INV  5'h10
`define SEL_DX_SINGLE_INV  5'h11
`define SEL_IC_FLUSH       5'h12
`define SEL_IC_GLOBAL      5'h13
`define SEL_ALTERNATE_MODE_SELECT       5'h14
`define SEL_CYCLE_CNT      5'h15
`define SEL_CYCLE_CTL      5'h16
`define SEL_CACHE_STATUS   5'h17
`define SEL_DC_ERR_ADDR    5'h18
`define SEL_BUS_STATUS     5'h19
`define SEL_BUS_ADDR       5'h1a
`define SEL_FILL_ADDR      5'h1b
`define SEL_FILL_SYND      5'h1c
`define SEL_BACKUP_TAG_CAPTURE         5'h1d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EXC_TRAP_LO        2
`define EXC_TRAP_HI        8
`define SUM_ASYNC_LO       29
`define SUM_SW_LO          14
`define WR_SW_LO           33
`define WR_ASYNC_LO        48
`define WR_HWEN_LO         9
`define DX_PFN_LO          32
`define DX_EN_LO           8
`define DX_ASM_BIT         4
`define DX_FOW_BIT         2
`define DX_FOR_BIT         1
`define VA_TAG_LO          13
`define ALTERNATE_MODE_SELECT_LO        3
`define CC_ENABLE_BIT      32
`define BUS_CMD_BLOCK_RD   3'h1
`define BUS_CMD_LOCKED_LD  3'h2
`define DX_ENTRIES         32
`define BACKUP_TAG_CAPTURE_W           23

`endif

//--- rtl/cpu_priv_pkg.sv
// Purpose : Types for the privileged register bank
// Assumes : Constants come from the params header
// Notes   : Whole bank state is one packed struct
package cpu_priv_pkg;
`include "cpu_priv_params.svh"

    typedef struct packed {
        logic        valid;
        logic [29:0] tag;
        logic        global_match_bit;
        logic [20:0] pfn;
        logic [3:0]  rd_en;
        logic [3:0]  wr_en;
        logic        fault_on_write;
        logic        fault_on_read;
    } dx_entry_t;

    typedef struct packed {
        dx_entry_t [`DX_ENTRIES-1:0] data_xlate_buffer;
        logic [4:0]  fill_ptr;
        logic [4:0]  read_ptr;
        dx_entry_t   dx_hold;
        logic [1:0]  cur_mode;
        logic [6:0]  exception_summary;
        logic [19:0] fw_base;
        logic [15:1] sw_irq_req;
        logic [3:0]  async_trap_req;
        logic [5:0]  hw_irq_en;
        logic [15:1] sw_irq_en;
        logic [3:0]  async_trap_en;
        logic        serial_tx;
        logic [1:0]  gran_hint;
        logic [14:0] fault_stat;
        logic [63:0] fault_va;
        logic        fault_lock;
        logic [1:0]  alternate_mode_select;
        logic [31:0] cc_count;
        logic [31:0] cc_offset;
        logic        cc_enable;
        logic [1:0]  cache_err;
        logic        cache_lock;
        logic [33:0] dc_err_addr;
        logic [14:0] bus_stat;
        logic        bus_lock;
        logic        fill_lock;
        logic [31:0] bus_addr;
        logic [28:0] fill_addr;
        logic [13:0] fill_synd;
        logic [`BACKUP_TAG_CAPTURE_W-1:0] backup_tag_capture;
        logic        bc_lock;
        logic [63:0] rdata;
        logic        rvalid;
        logic        irq;
        logic        ic_flush;
        logic        ic_global_flush;
    } bank_state_t;

endpackage

//--- rtl/cpu_privileged_register_bank.sv
// Purpose : Privileged register bank reached by move-to/move-from
// Assumes : All event inputs come from core logic on CLOCK
// Notes   : Read data returns one cycle after the move-from strobe
// Behaviour
// - Write to summary clears accumulated trap bits
// - Request read shows live requests, hardware request writes ignored
// - Hardware enable bits gate hardware requests
// - Software and async-trap enables gate per bit
// - Async trap request holds four mode bits
// - Entry register fills buffer, hold shows reads
// - Fault latches address and status until address read
// - Zap write invalidates all 32 entries
// - Global invalidate drops non-global entries only
// - Single invalidate drops entry matching address
// - Flush write invalidates whole instruction cache
// - Global flush drops non-global cache blocks
// - Alternate mode field sits in bits 4:3
// - Counter increments when enabled, control loads
// - Cache status freezes until error address read
// - Bus errors freeze status bits 6:0
// - Bus address read unlocks address and status
// - Address bits 4:2 zero except block read and locked load commands
// - Fill address read unlocks fill fields, syndrome
// - Syndrome locks two 7-bit halves
// - Backup tag loads per probe unless locked
// - Tag read returns LSB, shifts right
`timescale 1ns/10ps
module cpu_privileged_register_bank
    import cpu_priv_pkg::*;
#(
    parameter logic [2:0] CHIP_ID = 3'h5 // Arbitrary value
) (
    // Clock, reset, enable
    input  wire logic                 CLOCK,
    input  wire logic                 RST_B,
    input  wire logic                 CE,
    // Move-to / move-from port
    input  wire logic                 MT_VALID,
    input  wire logic                 MF_VALID,
    input  wire logic [`SEL_W-1:0]    REG_SEL,
    input  wire logic [63:0]          WDATA,
    input  wire logic [29:0]          XLATE_TAG,
    output logic      [63:0]          RDATA,
    output logic                      RVALID,
    // Core events
    input  wire logic [6:0]           TRAP_SET,
    input  wire logic [5:0]           HW_IRQ,
    input  wire logic                 FAULT_VALID,
    input  wire logic [63:0]          FAULT_VA_IN,
    input  wire logic [14:0]          FAULT_STAT_IN,
    input  wire logic                 CACHE_FILL_PERR,
    input  wire logic [1:0]           CACHE_ERR_IN,
    input  wire logic [33:0]          CACHE_ERR_ADDR,
    input  wire logic                 BUS_ERR_VALID,
    input  wire logic [3:0]           BUS_ERR_BITS,
    input  wire logic [2:0]           BUS_CMD,
    input  wire logic [33:0]          BUS_ERR_ADDR,
    input  wire logic                 FILL_ERR_VALID,
    input  wire logic [4:0]           FILL_ERR_BITS,
    input  wire logic [33:0]          FILL_ERR_ADDR,
    input  wire logic [13:0]          FILL_SYND_IN,
    input  wire logic                 TAG_PROBE,
    input  wire logic [`BACKUP_TAG_CAPTURE_W-1:0] TAG_PROBE_DATA,
    // Outputs to the core
    output logic                      INTR_REQ,
    output logic                      IC_FLUSH,
    output logic                      IC_GLOBAL_FLUSH,
    output logic [1:0]                ALTERNATE_MODE_SELECT_FIELD,
    output logic [1:0]                CURRENT_MODE,
    output logic                      SERIAL_TX
);

    bank_state_t r;
    bank_state_t n;
    logic        wr;
    logic        rd;
    logic [63:0] rsum;
    logic [63:0] rmux;
    dx_entry_t   e;
    logic        bus_lock_eff;
    logic        fill_lock_eff;

    assign wr = MT_VALID & CE;
    assign rd = MF_VALID & CE;

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        rsum = 64'h0;
        rsum[32:29] = r.async_trap_req;
        rsum[28:14] = r.sw_irq_req;
        rsum[12:10] = HW_IRQ[2:0];
        rsum[7:5]   = HW_IRQ[5:3];
        rsum[3]     = |(r.async_trap_req & r.async_trap_en);
        rsum[2]     = |(r.sw_irq_req & r.sw_irq_en);
        rsum[1]     = |(HW_IRQ & r.hw_irq_en);
        rmux = 64'h0;
        case (REG_SEL)
            `SEL_MODE: begin
                rmux[34] = r.cur_mode[1];
                rmux[1]  = r.cur_mode[0];
            end
            `SEL_EXCEPTION_SUMMARY:    rmux[`EXC_TRAP_HI:`EXC_TRAP_LO] = r.exception_summary;
            `SEL_FW_BASE:    rmux[33:14] = r.fw_base;
            `SEL_HW_IRQ_REQ, `SEL_SW_IRQ_REQ, `SEL_ASYNC_REQ:
                rmux = rsum;
            `SEL_HW_IRQ_EN, `SEL_SW_IRQ_EN, `SEL_ASYNC_EN: begin
                rmux[32:29] = r.async_trap_en;
                rmux[28:14] = r.sw_irq_en;
                rmux[12:10] = r.hw_irq_en[2:0];
                rmux[7:5]   = r.hw_irq_en[5:3];
            end
            `SEL_DX_HOLD: begin
                rmux[34]    = r.dx_hold.global_match_bit;
                rmux[33:13] = r.dx_hold.pfn;
                rmux[12:9]  = r.dx_hold.rd_en;
                rmux[8:5]   = r.dx_hold.wr_en;
                rmux[4]     = r.dx_hold.fault_on_write;
                rmux[3]     = r.dx_hold.fault_on_read;
            end
            `SEL_FAULT_STATUS: rmux[14:0] = r.fault_stat;
            `SEL_FAULT_VA:     rmux = r.fault_va;
            `SEL_CYCLE_CNT:    rmux = {r.cc_offset, r.cc_count};
            `SEL_CACHE_STATUS: rmux[5:0] = {r.cache_err, 1'b0, CHIP_ID};
            `SEL_DC_ERR_ADDR:  rmux[33:0] = r.dc_err_addr;
            `SEL_BUS_STATUS:   rmux[14:0] = r.bus_stat;
            `SEL_BUS_ADDR:     rmux[33:2] = r.bus_addr;
            `SEL_FILL_ADDR:    rmux[33:5] = r.fill_addr;
            `SEL_FILL_SYND:    rmux[13:0] = r.fill_synd;
            `SEL_BACKUP_TAG_CAPTURE:       rmux[0] = r.backup_tag_capture[0];
            default:           rmux = 64'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        e = '0;
        n.rvalid = rd;
        n.ic_flush = 1'b0;
        n.ic_global_flush = 1'b0;
        if (rd) begin
            n.rdata = rmux;
        end

        // Traps accumulate; a trap in the clearing cycle survives
        if (wr && REG_SEL == `SEL_EXCEPTION_SUMMARY) begin
            n.exception_summary = TRAP_SET;
        end else begin
            n.exception_summary = r.exception_summary | TRAP_SET;
        end

        if (wr) begin
            case (REG_SEL)
                `SEL_MODE:      n.cur_mode = WDATA[4:3];
                `SEL_FW_BASE:   n.fw_base = WDATA[33:14];
                `SEL_SW_IRQ_REQ: n.sw_irq_req = WDATA[47:`WR_SW_LO];
                `SEL_ASYNC_REQ: n.async_trap_req = WDATA[51:`WR_ASYNC_LO];
                `SEL_HW_IRQ_EN: n.hw_irq_en = WDATA[14:`WR_HWEN_LO];
                `SEL_SW_IRQ_EN: n.sw_irq_en = WDATA[47:`WR_SW_LO];
                `SEL_ASYNC_EN:  n.async_trap_en = WDATA[51:`WR_ASYNC_LO];
                `SEL_SERIAL_TX: n.serial_tx = WDATA[3];
                `SEL_XLATE_CTL: n.gran_hint = WDATA[6:5];
                `SEL_DX_ENTRY: begin
                    e = '0;
                    e.valid = 1'b1;
                    e.tag = XLATE_TAG;
                    e.global_match_bit = WDATA[`DX_ASM_BIT];
                    e.pfn = WDATA[52:`DX_PFN_LO];
                    e.rd_en = WDATA[11:`DX_EN_LO];
                    e.wr_en = WDATA[15:12];
                    e.fault_on_write = WDATA[`DX_FOW_BIT];
                    e.fault_on_read = WDATA[`DX_FOR_BIT];
                    n.data_xlate_buffer[r.fill_ptr] = e;
                    n.fill_ptr = r.fill_ptr + 5'h1;
                end
                `SEL_DX_ZAP: begin
                    for (int i = 0; i < `DX_ENTRIES; i++) begin
                        n.data_xlate_buffer[i].valid = 1'b0;
                    end
                end
                `SEL_DX_GLOBAL_INV: begin
                    for (int i = 0; i < `DX_ENTRIES; i++) begin
                        if (!r.data_xlate_buffer[i].global_match_bit) begin
                            n.data_xlate_buffer[i].valid = 1'b0;
                        end
                    end
                end
                `SEL_DX_SINGLE_INV: begin
                    for (int i = 0; i < `DX_ENTRIES; i++) begin
                        if (r.data_xlate_buffer[i].tag == WDATA[42:`VA_TAG_LO]) begin
                            n.data_xlate_buffer[i].valid = 1'b0;
                        end
                    end
                end
                `SEL_IC_FLUSH:  n.ic_flush = 1'b1;
                `SEL_IC_GLOBAL: n.ic_global_flush = 1'b1;
                `SEL_ALTERNATE_MODE_SELECT:  n.alternate_mode_select = WDATA[4:`ALTERNATE_MODE_SELECT_LO];
                `SEL_CYCLE_CNT: n.cc_offset = WDATA[63:32];
                default: ;
            endcase
        end

        // Read side effects
        if (rd && REG_SEL == `SEL_DX_ENTRY) begin
            n.dx_hold = r.data_xlate_buffer[r.read_ptr];
            n.read_ptr = r.read_ptr + 5'h1;
        end
        if (rd && REG_SEL == `SEL_FAULT_VA) begin
            n.fault_lock = 1'b0;
        end
        if (rd && REG_SEL == `SEL_DC_ERR_ADDR) begin
            n.cache_lock = 1'b0;
        end

        // Cycle counter
        if (r.cc_enable) begin
            n.cc_count = r.cc_count + 32'h1;
        end
        if (wr && REG_SEL == `SEL_CYCLE_CTL) begin
            n.cc_enable = WDATA[`CC_ENABLE_BIT];
            n.cc_count = WDATA[31:0];
        end

        // Fault capture; unlocking read and new fault may coincide
        if (FAULT_VALID && !n.fault_lock) begin
            n.fault_va = FAULT_VA_IN;
            n.fault_stat = FAULT_STAT_IN;
            n.fault_lock = 1'b1;
        end
        if (!n.cache_lock) begin
            n.cache_err = CACHE_ERR_IN;
            if (CACHE_FILL_PERR) begin
                n.dc_err_addr = CACHE_ERR_ADDR;
                n.cache_lock = 1'b1;
            end
        end

        // Bus unit errors
        bus_lock_eff = r.bus_lock && !(rd && REG_SEL == `SEL_BUS_ADDR);
        fill_lock_eff = r.fill_lock && !(rd && REG_SEL == `SEL_FILL_ADDR);
        n.bus_lock = bus_lock_eff;
        n.fill_lock = fill_lock_eff;
        if (BUS_ERR_VALID) begin
            if (bus_lock_eff) begin
                n.bus_stat[7] = 1'b1;
            end else begin
                n.bus_stat[3:0] = BUS_ERR_BITS;
                n.bus_stat[6:4] = BUS_CMD;
                n.bus_addr = BUS_ERR_ADDR[33:2];
                if (BUS_CMD != `BUS_CMD_BLOCK_RD && BUS_CMD != `BUS_CMD_LOCKED_LD) begin
                    n.bus_addr[2:0] = 3'h0;
                end
                n.bus_lock = |BUS_ERR_BITS;
            end
        end
        if (FILL_ERR_VALID) begin
            if (fill_lock_eff) begin
                n.bus_stat[14] = 1'b1;
            end else begin
                n.bus_stat[12:8] = FILL_ERR_BITS;
                n.fill_addr = FILL_ERR_ADDR[33:5];
                n.fill_synd = FILL_SYND_IN;
                n.fill_lock = FILL_ERR_BITS[0] | FILL_ERR_BITS[2];
            end
        end

        // Backup tag: shift on read, reload on probe, unlock on write
        if (rd && REG_SEL == `SEL_BACKUP_TAG_CAPTURE) begin
            n.backup_tag_capture = r.backup_tag_capture >> 1;
        end
        if (wr && REG_SEL == `SEL_BACKUP_TAG_CAPTURE) begin
            n.bc_lock = 1'b0;
        end
        if (TAG_PROBE && !n.bc_lock) begin
            n.backup_tag_capture = TAG_PROBE_DATA;
        end
        if ((BUS_ERR_VALID && |BUS_ERR_BITS[3:2]) ||
            (FILL_ERR_VALID && (FILL_ERR_BITS[0] | FILL_ERR_BITS[2]))) begin
            n.bc_lock = 1'b1;
        end

        n.irq = |(HW_IRQ & n.hw_irq_en) | |(n.sw_irq_req & n.sw_irq_en) |
                |(n.async_trap_req & n.async_trap_en);
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            r <= '0;
        end else if (CE) begin
            r <= n;
        end
    end

    assign RDATA = r.rdata;
    assign RVALID = r.rvalid;
    assign INTR_REQ = r.irq;
    assign IC_FLUSH = r.ic_flush;
    assign IC_GLOBAL_FLUSH = r.ic_global_flush;
    assign ALTERNATE_MODE_SELECT_FIELD = r.alternate_mode_select;
    assign CURRENT_MODE = r.cur_mode;
    assign SERIAL_TX = r.serial_tx;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_exc_clear: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr && REG_SEL == `SEL_EXCEPTION_SUMMARY && TRAP_SET == 7'h0 |=> r.exception_summary == 7'h0)
        else $error("summary not cleared by write");
    a_req_live: assert property (@(posedge CLOCK) disable iff (!RST_B)
        rd && REG_SEL == `SEL_HW_IRQ_REQ |=> RVALID && RDATA[12:10] == $past(HW_IRQ[2:0]))
        else $error("request read not live");
    a_irq_gate: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && r.hw_irq_en == 6'h0 && r.sw_irq_en == 15'h0 && r.async_trap_en == 4'h0
        && !wr |=> !INTR_REQ)
        else $error("interrupt raised while all disabled");
    a_async_rw: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr && REG_SEL == `SEL_ASYNC_REQ ##1 rd && !wr && REG_SEL == `SEL_ASYNC_REQ
        |=> RDATA[32:29] == $past(WDATA[51:48], 2))
        else $error("async request readback wrong");
    a_va_lock: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && r.fault_lock && !(rd && REG_SEL == `SEL_FAULT_VA) |=> $stable(r.fault_va))
        else $error("fault address changed while locked");
    a_zap_all: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr && REG_SEL == `SEL_DX_ZAP |=> r.data_xlate_buffer[0].valid == 1'b0 && r.data_xlate_buffer[31].valid == 1'b0)
        else $error("entries survive zap");
    a_cc_count: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && r.cc_enable && !(wr && REG_SEL == `SEL_CYCLE_CTL)
        |=> r.cc_count == $past(r.cc_count) + 32'h1)
        else $error("counter did not advance");
    a_bus_freeze: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && r.bus_lock && !(rd && REG_SEL == `SEL_BUS_ADDR)
        |=> r.bus_stat[6:0] == $past(r.bus_stat[6:0]))
        else $error("bus status moved while locked");
    a_addr_zero: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && BUS_ERR_VALID && !bus_lock_eff && BUS_CMD == 3'h0 |=> r.bus_addr[2:0] == 3'h0)
        else $error("address bits 4:2 not zero");
    a_tag_shift: assert property (@(posedge CLOCK) disable iff (!RST_B)
        rd && REG_SEL == `SEL_BACKUP_TAG_CAPTURE && r.bc_lock && !wr
        |=> r.backup_tag_capture == ($past(r.backup_tag_capture) >> 1) && RDATA[0] == $past(r.backup_tag_capture[0]))
        else $error("tag read did not shift");
    c_fault_lock: cover property (@(posedge CLOCK) disable iff (!RST_B)
        r.fault_lock ##1 rd && REG_SEL == `SEL_FAULT_VA ##1 !r.fault_lock);
    c_bus_fatal: cover property (@(posedge CLOCK) disable iff (!RST_B)
        r.bus_lock && BUS_ERR_VALID && CE ##1 r.bus_stat[7]);
    c_irq_up: cover property (@(posedge CLOCK) disable iff (!RST_B) $rose(INTR_REQ));

endmodule // cpu_privileged_register_bank

//--- sim/cpu_privileged_register_bank_tb.sv
// Purpose : Self-checking bench for the privileged register bank
// Assumes : Select codes come from the params header
// Notes   : Five quiet inputs are tied; cache status format left unchecked
`timescale 1ns/10ps
`include "cpu_priv_params.svh"
module cpu_privileged_register_bank_tb import cpu_priv_pkg::*;;
    logic        clock = 1'b0, rst_b = 1'b0, mt = 1'b0, mf = 1'b0;
    logic        fv = 1'b0, bv = 1'b0, flv = 1'b0, tp = 1'b0;
    logic [4:0]  sel = 5'h0, flbits = 5'h0;
    logic [63:0] wd = 64'h0, fva = 64'h0, rd_v, prev, rdata;
    logic [14:0] fst = 15'h0;
    logic [6:0]  trap = 7'h0;
    logic [5:0]  hw = 6'h0;
    logic [3:0]  bbits = 4'h0;
    logic [2:0]  bcmd = 3'h0;
    logic [33:0] baddr = 34'h0, fladdr = 34'h0;
    logic [13:0] synd = 14'h0;
    logic [22:0] tpd = 23'h0;
    logic        rvalid, intr, icf, icg;
    logic [1:0]  alt, cm;
    logic        stx;
    int          fails = 0, checks = 0, cyc = 0;

    cpu_privileged_register_bank dut (.CLOCK(clock), .RST_B(rst_b), .CE(1'b1),
        .MT_VALID(mt), .MF_VALID(mf), .REG_SEL(sel), .WDATA(wd), .XLATE_TAG(30'h0),
        .RDATA(rdata), .RVALID(rvalid), .TRAP_SET(trap), .HW_IRQ(hw),
        .FAULT_VALID(fv), .FAULT_VA_IN(fva), .FAULT_STAT_IN(fst),
        .CACHE_FILL_PERR(1'b0), .CACHE_ERR_IN(2'h0), .CACHE_ERR_ADDR(34'h0),
        .BUS_ERR_VALID(bv), .BUS_ERR_BITS(bbits), .BUS_CMD(bcmd), .BUS_ERR_ADDR(baddr),
        .FILL_ERR_VALID(flv), .FILL_ERR_BITS(flbits), .FILL_ERR_ADDR(fladdr),
        .FILL_SYND_IN(synd), .TAG_PROBE(tp), .TAG_PROBE_DATA(tpd), .INTR_REQ(intr),
        .IC_FLUSH(icf), .IC_GLOBAL_FLUSH(icg), .ALTERNATE_MODE_SELECT_FIELD(alt),
        .CURRENT_MODE(cm), .SERIAL_TX(stx));

    // ------------------------------------------------------------
    // Bus cycles and checks
    // ------------------------------------------------------------
    always #5 clock = ~clock;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] s, input logic [63:0] d);
        @(posedge clock);
        mt <= 1'b1;
        sel <= s;
        wd <= d;
        @(posedge clock);
        mt <= 1'b0;
    endtask
    // Read data lands on the same edge that takes the strobe
    task automatic rd(input logic [4:0] s);
        @(posedge clock);
        mf <= 1'b1;
        sel <= s;
        @(posedge clock);
        mf <= 1'b0;
        #1;
        chk({63'h0, rvalid}, 64'h1);
        rd_v = rdata;
    endtask
    // Registered request output updates on the edge the write lands; checked one edge later
    task automatic en_chk(input logic [4:0] s, input logic [63:0] d, input logic e);
        wr(s, d);
        @(posedge clock);
        #1;
        chk({63'h0, intr}, {63'h0, e});
    endtask
    task automatic probe(input logic [22:0] d);
        @(posedge clock);
        tp <= 1'b1;
        tpd <= d;
        @(posedge clock);
        tp <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_entry;
        wr(`SEL_DX_ENTRY, {11'h0, 21'h1abcd, 16'h0, 4'h5, 4'ha, 8'h14});
        rd(`SEL_DX_ENTRY);
        chk(rd_v, 64'h0);
        rd(`SEL_DX_HOLD);
        chk(rd_v, {29'h0, 1'b1, 21'h1abcd, 4'ha, 4'h5, 5'h10});
    endtask
    task automatic t_summary;
        @(posedge clock);
        trap <= 7'h41;
        @(posedge clock);
        trap <= 7'h0;
        rd(`SEL_EXCEPTION_SUMMARY);
        chk(rd_v, 64'h104);
        wr(`SEL_EXCEPTION_SUMMARY, 64'hffff_ffff_ffff_ffff);
        rd(`SEL_EXCEPTION_SUMMARY);
        chk(rd_v, 64'h0);
    endtask
    task automatic t_irq;
        @(posedge clock);
        hw <= 6'h2d;
        rd(`SEL_HW_IRQ_REQ);
        chk(rd_v & ~64'h2, 64'h14a0);
        chk({63'h0, intr}, 64'h0);
        wr(`SEL_HW_IRQ_REQ, 64'hffff_ffff_ffff_ffff);
        en_chk(`SEL_HW_IRQ_EN, 64'h200, 1'b1);
        en_chk(`SEL_HW_IRQ_EN, 64'h400, 1'b0);
        rd(`SEL_HW_IRQ_REQ);
        chk(rd_v & ~64'h2, 64'h14a0);
        hw <= 6'h0;
        wr(`SEL_ASYNC_REQ, 64'ha << 48);
        rd(`SEL_ASYNC_REQ);
        chk(rd_v & ~64'hf, 64'ha << 29);
        en_chk(`SEL_ASYNC_EN, 64'h5 << 48, 1'b0);
        en_chk(`SEL_ASYNC_EN, 64'h8 << 48, 1'b1);
        wr(`SEL_ASYNC_REQ, 64'h0);
        wr(`SEL_SW_IRQ_REQ, 64'h1 << 47);
        rd(`SEL_SW_IRQ_REQ);
        chk(rd_v & ~64'hf, 64'h1 << 28);
        en_chk(`SEL_SW_IRQ_EN, 64'h1 << 46, 1'b0);
        en_chk(`SEL_SW_IRQ_EN, 64'h1 << 47, 1'b1);
        wr(`SEL_SW_IRQ_REQ, 64'h0);
    endtask
    task automatic t_fault;
        @(posedge clock);
        fv <= 1'b1;
        fva <= 64'h1111_2222_3333_4440;
        fst <= 15'h1234;
        @(posedge clock);
        fva <= 64'h5555_6666_7777_8880;
        fst <= 15'h0bad;
        @(posedge clock);
        fv <= 1'b0;
        rd(`SEL_FAULT_STATUS);
        chk(rd_v, 64'h1234);
        rd(`SEL_FAULT_VA);
        chk(rd_v, 64'h1111_2222_3333_4440);
        @(posedge clock);
        fv <= 1'b1;
        @(posedge clock);
        fv <= 1'b0;
        rd(`SEL_FAULT_VA);
        chk(rd_v, 64'h5555_6666_7777_8880);
        rd(`SEL_FAULT_STATUS);
        chk(rd_v, 64'h0bad);
    endtask
    task automatic t_ctl;
        for (int m = 0; m < 4; m++) begin
            wr(`SEL_ALTERNATE_MODE_SELECT, {59'h0, m[1:0], 3'h7});
            #1;
            chk({62'h0, alt}, {62'h0, m[1:0]});
        end
        wr(`SEL_MODE, 64'h18);
        wr(`SEL_SERIAL_TX, 64'h8);
        #1;
        chk({61'h0, cm, stx}, 64'h7);
        rd(`SEL_MODE);
        chk(rd_v, 64'h4_0000_0002);
        wr(`SEL_IC_FLUSH, 64'h0);
        #1;
        chk({62'h0, icf, icg}, 64'h2);
        wr(`SEL_IC_GLOBAL, 64'h0);
        #1;
        chk({62'h0, icf, icg}, 64'h1);
        wr(`SEL_CYCLE_CTL, 64'h1_0000_0005);
        rd(`SEL_CYCLE_CNT);
        prev = rd_v;
        rd(`SEL_CYCLE_CNT);
        chk({32'h0, rd_v[31:0] - prev[31:0]}, 64'h2);
        wr(`SEL_CYCLE_CTL, 64'h9);
        rd(`SEL_CYCLE_CNT);
        rd(`SEL_CYCLE_CNT);
        chk({32'h0, rd_v[31:0]}, 64'h9);
    endtask
    // Second error arrives while the first is still held
    task automatic t_errors;
        probe(23'h5);
        for (int i = 0; i < 3; i++) begin
            rd(`SEL_BACKUP_TAG_CAPTURE);
            chk(rd_v, {63'h0, ~i[0]});
        end
        @(posedge clock);
        bv <= 1'b1;
        baddr <= 34'h2_dead_beef;
        bbits <= 4'h1;
        @(posedge clock);
        bbits <= 4'h2;
        bcmd <= 3'h3;
        baddr <= 34'h1_0000_0100;
        @(posedge clock);
        bv <= 1'b0;
        rd(`SEL_BUS_STATUS);
        chk(rd_v & 64'hff, 64'h81);
        rd(`SEL_BUS_ADDR);
        chk(rd_v, 64'h2_dead_bee0);
        @(posedge clock);
        bv <= 1'b1;
        bbits <= 4'h1;
        bcmd <= 3'h1;
        baddr <= 34'h3_0000_00fc;
        @(posedge clock);
        bv <= 1'b0;
        rd(`SEL_BUS_STATUS);
        chk(rd_v & 64'h7f, 64'h11);
        rd(`SEL_BUS_ADDR);
        chk(rd_v & ~64'h1f, 64'h3_0000_00e0);
        @(posedge clock);
        flv <= 1'b1;
        flbits <= 5'h01;
        fladdr <= 34'h1_2345_67ff;
        synd <= 14'h2a5c;
        @(posedge clock);
        fladdr <= 34'h40;
        synd <= 14'h1111;
        @(posedge clock);
        flv <= 1'b0;
        rd(`SEL_FILL_SYND);
        chk(rd_v, 64'h2a5c);
        rd(`SEL_BUS_STATUS);
        chk(rd_v & 64'h7f00, 64'h4100);
        rd(`SEL_FILL_ADDR);
        chk(rd_v & ~64'h1f, 64'h1_2345_67e0);
        probe(23'h1);
        rd(`SEL_BACKUP_TAG_CAPTURE);
        chk(rd_v, 64'h0);
        wr(`SEL_BACKUP_TAG_CAPTURE, 64'h0);
        probe(23'h1);
        rd(`SEL_BACKUP_TAG_CAPTURE);
        chk(rd_v, 64'h1);
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            stop_test;
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_entry;
        t_summary;
        t_irq;
        t_fault;
        t_ctl;
        t_errors;
        stop_test;
    end
endmodule // cpu_privileged_register_bank_tb
